// [inc/bod_params.svh]
// Purpose: named constants of the byte op decode/execute slice
// Assumes: 16-bit program words, 12-bit data addresses
// Notes: opcodes are matched on the upper bits of the first word
`ifndef BOD_PARAMS_SVH
`define BOD_PARAMS_SVH

`define BOD_OP_INCSZ 6'h0f
`define BOD_OP_INCSNZ 6'h12
`define BOD_OP_ORLOC 6'h04
`define BOD_OP_MOVLOC 6'h14
`define BOD_OP_STACC 7'h37
`define BOD_OP_ORIMM 8'h09
`define BOD_OP_LDBANK 8'h01
`define BOD_OP_LDIMM 8'h0e
`define BOD_OP_LDPTR 8'hee
`define BOD_OP_MOVMM 4'hc
`define BOD_OP_SECOND 4'hf

`define BOD_PH_Q1 2'h0
`define BOD_PH_Q2 2'h1
`define BOD_PH_Q3 2'h2
`define BOD_PH_Q4 2'h3

`define BOD_IDX_LIMIT 8'h5f
`define BOD_ACC_SPLIT 8'h80
`define BOD_ACC_HI_PAGE 4'hf
`define BOD_ACC_LO_PAGE 4'h0
`define BOD_PTR_IDX 2'h2
`define BOD_PTR_MAX 2'h2

`define BOD_REG_ACC 3'h0
`define BOD_REG_BANK 3'h1
`define BOD_REG_FLAGS 3'h2
`define BOD_REG_CTRL 3'h3
`define BOD_REG_STATE 3'h4

`define BOD_RST_ACC 8'h00
`define BOD_RST_BANK 4'h0
`define BOD_MEM_DEPTH 4096
`endif

// [inc/bod_pkg.sv]
// Purpose: shared types of the byte op decode/execute slice
// Assumes: constants live in bod_params.svh
// Notes: none
package bod_pkg;
   typedef enum logic [1:0] {BOD_ALU_PASS, BOD_ALU_OR, BOD_ALU_INC} bod_alu_op_t;
   typedef enum logic [2:0] {BOD_ST_EXEC, BOD_ST_SKIP1, BOD_ST_SKIP2, BOD_ST_MOV2, BOD_ST_PTR2} bod_state_t;
   typedef struct packed {
      logic we;
      logic [11:0] addr;
      logic [7:0] wdata;
   } bod_mem_req_t;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bod_reg_req_t;
endpackage

// [core/bod_dmem.sv]
// Purpose: banked data memory, one port, registered read data
// Assumes: one access per clock
// Notes: read data stand the cycle after the address
`timescale 1ns/1ps
`include "bod_params.svh"
module bod_dmem
   import bod_pkg::*;
(
   input wire logic clk,
   input bod_mem_req_t req,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:`BOD_MEM_DEPTH-1];
   // no reset on the array: it would not map to a ram
   always_ff @(posedge clk) begin
      if (req.we) begin
         mem[req.addr] <= req.wdata;
      end
      rdata <= mem[req.addr];
   end
endmodule // bod_dmem

// [core/bod_alu.sv]
// Purpose: byte result path with negative and zero flags
// Assumes: purely combinational
// Notes: no carry out; the slice never needs one
`timescale 1ns/1ps
module bod_alu
   import bod_pkg::*;
(
   input bod_alu_op_t op,
   input wire logic [7:0] acc,
   input wire logic [7:0] opnd,
   output logic [7:0] res,
   output logic neg,
   output logic zero
);
   always_comb begin
      case (op)
         BOD_ALU_OR: res = acc | opnd;
         BOD_ALU_INC: res = opnd + 8'h01;
         default: res = opnd;
      endcase
      neg = res[7];
      zero = (res == 8'h00);
   end
endmodule // bod_alu

// [core/bod_core.sv]
// Purpose: decode and execute for one slice of an 8-bit core
// Assumes: one program word offered per instruction cycle, four clocks a cycle
// Notes: data memory lives inside; a small register port exposes state
// Functional notes
// [RL1] increment and skip on nonzero writes the sum to its destination, keeps flags, skips if nonzero.
// [RL2] a taken skip discards the prefetched word and runs a no-operation cycle in its place.
// [RL3] a skip instruction takes one cycle, two when skipping, three when skipping a two-word one.
// [RL4] access bit zero selects the fast access bank, one selects the bank by the bank select register.
// [RL5] extended set on with access bit zero treats an operand of 95 or less as a pointer offset.
// [RL6] or immediate into acc ors an 8-bit literal into the acc in one cycle, touching only N and Z.
// [RL7] load pointer immediate writes the high part to the pointer upper byte, the low byte to the lower.
// [RL8] load pointer immediate takes selectors 0 to 2 and spends two words and two cycles.
// [RL9] memory to memory move reads the source in cycle one and writes the destination in cycle two.
// [RL10] load bank nibble writes the low nibble of the bank register; bits 7:4 stay zero.
// [RL11] load immediate acc copies an 8-bit literal into the acc in one cycle, flags unchanged.
// [RL12] store acc copies the acc into the target location in one cycle, flags unchanged.
// [RL13] the 8-bit target of a single-word store reaches any byte of the addressed bank.
// [RL14] a destination bit of zero sends the result to the acc, one writes back to the location.
// [RL15] increment and skip on zero skips only when the sum is zero.
// [RL16] or acc with location and move location place the result in one cycle, touching only N and Z.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "bod_params.svh"
module bod_core
   import bod_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] fetch_word,
   input wire logic fetch_valid,
   output logic fetch_take,
   output logic cycle_done,
   output logic skip_taken,
   input bod_reg_req_t reg_req,
   output logic [7:0] reg_rdata
);

   ////////////////////////////////////////////////////////////////
   typedef struct packed {
      bod_state_t st;
      logic [1:0] ph;
      logic [15:0] ir;
      logic [7:0] acc;
      logic [3:0] bank;
      logic [2:0][11:0] ptr;
      logic flag_n;
      logic flag_z;
      logic ext_en;
      logic [7:0] hold;
      logic [1:0] sel;
      logic [7:0] res;
      logic res_n;
      logic res_z;
      logic skip;
      logic [7:0] rdata;
   } bod_core_st_t;

   bod_core_st_t r_reg;
   bod_core_st_t r_next;
   bod_mem_req_t mem_req;
   logic [7:0] mem_rdata;
   bod_alu_op_t alu_op;
   logic [7:0] alu_opnd;
   logic [7:0] alu_res;
   logic alu_neg;
   logic alu_zero;

   ////////////////////////////////////////////////////////////////
   // decode of the latched first word
   logic [7:0] f_op;
   logic dbit;
   logic abit;
   logic is_incsz;
   logic is_incsnz;
   logic is_orloc;
   logic is_movloc;
   logic is_stacc;
   logic is_orimm;
   logic is_ldbank;
   logic is_ldimm;
   logic is_ldptr;
   logic is_movmm;
   logic uses_mem;
   logic [11:0] ea;

   assign f_op = r_reg.ir[7:0];
   assign dbit = r_reg.ir[9];
   assign abit = r_reg.ir[8];
   assign is_incsz = r_reg.ir[15:10] == `BOD_OP_INCSZ;
   assign is_incsnz = r_reg.ir[15:10] == `BOD_OP_INCSNZ;
   assign is_orloc = r_reg.ir[15:10] == `BOD_OP_ORLOC;
   assign is_movloc = r_reg.ir[15:10] == `BOD_OP_MOVLOC;
   assign is_stacc = r_reg.ir[15:9] == `BOD_OP_STACC;
   assign is_orimm = r_reg.ir[15:8] == `BOD_OP_ORIMM;
   assign is_ldbank = r_reg.ir[15:8] == `BOD_OP_LDBANK;
   assign is_ldimm = r_reg.ir[15:8] == `BOD_OP_LDIMM;
   assign is_ldptr = r_reg.ir[15:8] == `BOD_OP_LDPTR;
   assign is_movmm = r_reg.ir[15:12] == `BOD_OP_MOVMM;
   assign uses_mem = is_incsz | is_incsnz | is_orloc | is_movloc;

   // a word that needs a second fetch; a skip over it must eat both
   function automatic logic two_word(input logic [15:0] w);
      two_word = (w[15:12] == `BOD_OP_MOVMM) || (w[15:8] == `BOD_OP_LDPTR);
   endfunction

   ////////////////////////////////////////////////////////////////
   // effective byte address for byte ops
   // the indexed window only opens with the access bit clear, so banked code never moves
   always_comb begin
      if (abit) begin
         ea = {r_reg.bank, f_op}; // RL4 RL13
      end else if (r_reg.ext_en && (f_op <= `BOD_IDX_LIMIT)) begin
         ea = r_reg.ptr[`BOD_PTR_IDX] + {4'h0, f_op}; // RL5
      end else if (f_op < `BOD_ACC_SPLIT) begin
         ea = {`BOD_ACC_LO_PAGE, f_op}; // RL4
      end else begin
         ea = {`BOD_ACC_HI_PAGE, f_op}; // RL4
      end
   end

   ////////////////////////////////////////////////////////////////
   always_comb begin
      if (is_orloc | is_orimm) begin
         alu_op = BOD_ALU_OR;
      end else if (is_incsz | is_incsnz) begin
         alu_op = BOD_ALU_INC;
      end else begin
         alu_op = BOD_ALU_PASS;
      end
      alu_opnd = (is_orimm | is_ldimm) ? f_op : mem_rdata;
   end

   bod_alu u_alu (
      .op(alu_op),
      .acc(r_reg.acc),
      .opnd(alu_opnd),
      .res(alu_res),
      .neg(alu_neg),
      .zero(alu_zero)
   );

   bod_dmem u_mem (
      .clk(clk),
      .req(mem_req),
      .rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////
   always_comb begin
      r_next = r_reg;
      fetch_take = 1'b0;
      cycle_done = 1'b0;
      skip_taken = 1'b0;
      mem_req = '0;
      mem_req.addr = ea;

      // register port first, so the running instruction wins a clash
      if (reg_req.wr) begin
         if (reg_req.addr == `BOD_REG_ACC) begin
            r_next.acc = reg_req.wdata;
         end else if (reg_req.addr == `BOD_REG_CTRL) begin
            r_next.ext_en = reg_req.wdata[0];
         end
      end
      // read data come from a register so they stand until the next read
      if (reg_req.rd) begin
         if (reg_req.addr == `BOD_REG_ACC) begin
            r_next.rdata = r_reg.acc;
         end else if (reg_req.addr == `BOD_REG_BANK) begin
            r_next.rdata = {4'h0, r_reg.bank};
         end else if (reg_req.addr == `BOD_REG_FLAGS) begin
            r_next.rdata = {6'h00, r_reg.flag_n, r_reg.flag_z};
         end else if (reg_req.addr == `BOD_REG_CTRL) begin
            r_next.rdata = {7'h00, r_reg.ext_en};
         end else if (reg_req.addr == `BOD_REG_STATE) begin
            r_next.rdata = {1'b0, r_reg.st, r_reg.skip, 1'b0, r_reg.ph};
         end else begin
            r_next.rdata = 8'h00;
         end
      end

      case (r_reg.ph)
         `BOD_PH_Q1: begin
            // wait on the fetch path; nothing moves without a word
            if (fetch_valid) begin
               fetch_take = 1'b1;
               r_next.ir = fetch_word;
               r_next.ph = `BOD_PH_Q2;
            end
         end
         `BOD_PH_Q2: begin
            if (r_reg.st == BOD_ST_EXEC && is_movmm) begin
               mem_req.addr = r_reg.ir[11:0]; // RL9
            end
            r_next.ph = `BOD_PH_Q3;
         end
         `BOD_PH_Q3: begin
            // result is registered so the Q4 write never rides the memory output
            if (r_reg.st == BOD_ST_EXEC) begin
               r_next.res = alu_res;
               r_next.res_n = alu_neg;
               r_next.res_z = alu_zero;
               if (is_movmm) begin
                  r_next.hold = mem_rdata; // RL9
               end
            end
            r_next.ph = `BOD_PH_Q4;
         end
         default: begin
            cycle_done = 1'b1;
            r_next.ph = `BOD_PH_Q1;
            r_next.skip = 1'b0;
            case (r_reg.st)
               BOD_ST_EXEC: begin
                  if (uses_mem) begin
                     if (dbit) begin
                        mem_req.we = 1'b1; // RL14
                        mem_req.wdata = r_reg.res;
                     end else begin
                        r_next.acc = r_reg.res; // RL14
                     end
                  end
                  if (is_orloc | is_movloc) begin
                     r_next.flag_n = r_reg.res_n; // RL16
                     r_next.flag_z = r_reg.res_z; // RL16
                  end
                  if (is_incsnz && !r_reg.res_z) begin
                     r_next.st = BOD_ST_SKIP1; // RL1
                     r_next.skip = 1'b1;
                  end
                  if (is_incsz && r_reg.res_z) begin
                     r_next.st = BOD_ST_SKIP1; // RL15
                     r_next.skip = 1'b1;
                  end
                  if (is_orimm) begin
                     r_next.acc = r_reg.res; // RL6
                     r_next.flag_n = r_reg.res_n; // RL6
                     r_next.flag_z = r_reg.res_z; // RL6
                  end
                  if (is_ldimm) begin
                     r_next.acc = r_reg.res; // RL11
                  end
                  if (is_ldbank) begin
                     r_next.bank = f_op[3:0]; // RL10
                  end
                  if (is_stacc) begin
                     mem_req.we = 1'b1; // RL12
                     mem_req.wdata = r_reg.acc;
                  end
                  if (is_movmm) begin
                     r_next.st = BOD_ST_MOV2; // RL9
                  end
                  // selector 3 names no pointer: the word passes as a one-cycle no-op
                  if (is_ldptr && r_reg.ir[5:4] <= `BOD_PTR_MAX) begin
                     r_next.sel = r_reg.ir[5:4]; // RL8
                     r_next.ptr[r_reg.ir[5:4]][11:8] = r_reg.ir[3:0]; // RL7
                     r_next.st = BOD_ST_PTR2; // RL8
                  end
               end
               BOD_ST_SKIP1: begin
                  // the prefetched word is dropped and this cycle is a no-op
                  skip_taken = 1'b1; // RL2
                  r_next.st = two_word(r_reg.ir) ? BOD_ST_SKIP2 : BOD_ST_EXEC; // RL3
               end
               BOD_ST_SKIP2: begin
                  r_next.st = BOD_ST_EXEC; // RL3
               end
               BOD_ST_MOV2: begin
                  // second word is a destination only; no dummy read is made
                  mem_req.we = 1'b1; // RL9
                  mem_req.addr = r_reg.ir[11:0]; // RL9
                  mem_req.wdata = r_reg.hold;
                  r_next.st = BOD_ST_EXEC;
               end
               BOD_ST_PTR2: begin
                  r_next.ptr[r_reg.sel][7:0] = f_op; // RL7
                  r_next.st = BOD_ST_EXEC; // RL8
               end
               default: begin
                  // unused state codes drop back to decode rather than lock up
                  r_next.st = BOD_ST_EXEC;
               end
            endcase
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0;
         r_reg.st <= BOD_ST_EXEC;
         r_reg.ph <= `BOD_PH_Q1;
         r_reg.acc <= `BOD_RST_ACC;
         r_reg.bank <= `BOD_RST_BANK;
      end else begin
         r_reg <= r_next;
      end
   end

   assign reg_rdata = r_reg.rdata;

endmodule // bod_core

// [verif/bod_core_props.sv]
// Purpose: port assertions for bod_core
// Assumes: four clocks per instruction cycle, register map as handed over
// Notes: bound to every bod_core instance
`timescale 1ns/1ps
`include "bod_params.svh"
module bod_core_props
   import bod_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [15:0] fetch_word,
   input wire logic fetch_valid,
   input wire logic fetch_take,
   input wire logic cycle_done,
   input wire logic skip_taken,
   input bod_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////
   take_done_a: assert property (fetch_take |-> ##3 cycle_done) else $error("cycle end missed");
   done_gap_a: assert property (cycle_done |=> !cycle_done [*3]) else $error("cycle too short");
   take_gap_a: assert property (fetch_take |=> !fetch_take [*3]) else $error("word taken early");
   take_valid_a: assert property (fetch_take |-> fetch_valid) else $error("take without word");
   skip_done_a: assert property (skip_taken |-> cycle_done) else $error("skip off cycle end");
   // a skip needs its own instruction cycle first, so two no-op cycles never both flag
   skip_gap_a: assert property (skip_taken |=> !skip_taken [*7]) else $error("skip flagged twice");
   ctrl_rw_a: assert property ((reg_req.wr && reg_req.addr == `BOD_REG_CTRL) ##1
      (reg_req.rd && reg_req.addr == `BOD_REG_CTRL) |=> reg_rdata[0] == $past(reg_req.wdata[0], 2))
      else $error("mode bit lost");
   bank_hi_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) == `BOD_REG_BANK
      |-> reg_rdata[7:4] == 4'h0) else $error("bank upper bits set");
   unmapped_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) > `BOD_REG_STATE
      |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
   rdata_hold_a: assert property (!$past(reg_req.rd) |-> $stable(reg_rdata)) else $error("read data moved");
endmodule // bod_core_props

bind bod_core bod_core_props bod_core_props_i (.clk(clk), .resetn(resetn), .fetch_word(fetch_word),
   .fetch_valid(fetch_valid), .fetch_take(fetch_take), .cycle_done(cycle_done), .skip_taken(skip_taken),
   .reg_req(reg_req), .reg_rdata(reg_rdata));

// [verif/bod_fetch_model.sv]
// Purpose: program fetch path offering words to bod_core
// Assumes: words pushed in program order
// Notes: an offer stands until taken; hold only delays a new offer
`timescale 1ns/1ps
module bod_fetch_model (
   input wire logic clk,
   input wire logic resetn,
   input wire logic push,
   input wire logic [15:0] push_word,
   input wire logic hold,
   input wire logic fetch_take,
   output logic fetch_valid,
   output logic [15:0] fetch_word
);
   logic [15:0] q[$];
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q.delete();
         fetch_valid <= 1'b0;
         fetch_word <= 16'h0000;
      end else begin
         if (push) begin
            q.push_back(push_word);
         end
         if (fetch_valid && fetch_take) begin
            void'(q.pop_front());
         end
         if (!(fetch_valid && !fetch_take)) begin
            if (q.size() > 0 && !hold) begin
               fetch_valid <= 1'b1;
               fetch_word <= q[0];
            end else begin
               // idle bus toggles so a stale word is never mistaken for a live one
               fetch_valid <= 1'b0;
               fetch_word <= ~fetch_word;
            end
         end
      end
   end
endmodule // bod_fetch_model

// [verif/bod_core_tb_top.sv]
// Purpose: self-checking bench for bod_core
// Assumes: results are observed through the register port
// Notes: literals and fetch stalls come from a fixed load_pointer_immediate
`timescale 1ns/1ps
`include "bod_params.svh"
module bod_core_tb_top
   import bod_pkg::*;
;
   logic clk, resetn, push, hold, fetch_valid, fetch_take, cycle_done, skip_taken, rd_pend;
   logic [15:0] push_word, fetch_word;
   logic [7:0] reg_rdata, k;
   logic [31:0] rnd;
   bod_reg_req_t reg_req;
   logic [10:0] expq[$];
   int n_mismatch, tests_run;
   bod_core bod_core_i (.clk(clk), .resetn(resetn), .fetch_word(fetch_word), .fetch_valid(fetch_valid),
      .fetch_take(fetch_take), .cycle_done(cycle_done), .skip_taken(skip_taken), .reg_req(reg_req),
      .reg_rdata(reg_rdata));
   bod_fetch_model bod_fetch_model_i (.clk(clk), .resetn(resetn), .push(push), .push_word(push_word),
      .hold(hold), .fetch_take(fetch_take), .fetch_valid(fetch_valid), .fetch_word(fetch_word));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] load_pointer_immediate_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      reg_req <= '0;
   endtask
   // write then read back with no gap, as the port allows
   task wr_rd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] exp);
      @(posedge clk);
      reg_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      reg_req <= '{a, 8'h00, 1'b0, 1'b1};
      expq.push_back({a, exp});
      @(posedge clk);
      reg_req <= '0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_req <= '{a, 8'h00, 1'b0, 1'b1};
      expq.push_back({a, exp});
      @(posedge clk);
      reg_req <= '0;
   endtask
   // pushes a program and waits for one cycle end per word, counting skips
   task run(input logic [15:0] w[$], input logic [7:0] skips);
      int n, s, i;
      n = 0;
      s = 0;
      for (i = 0; i < 40 * w.size() && n < w.size(); i++) begin
         @(posedge clk);
         push <= (i < w.size());
         push_word <= w[i % w.size()];
         n += (cycle_done === 1'b1);
         s += (skip_taken === 1'b1);
      end
      if (n < w.size()) begin
         n_mismatch++;
         $display("ERROR cycle_end_count expected %0d seen %0d", w.size(), n);
         tally_and_finish;
      end else begin
         check("skip_count", s[7:0], skips);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      rnd <= resetn ? load_pointer_immediate_next(rnd) : 32'he9e2;
      hold <= rnd[2] & rnd[5];
   end
   always @(posedge clk) begin
      if (rd_pend) begin
         check($sformatf("reg%0d", expq[0][10:8]), reg_rdata, expq[0][7:0]);
         void'(expq.pop_front());
      end
      rd_pend <= reg_req.rd;
   end
   initial begin
      {resetn, push} = 2'h0;
      push_word = 16'h0000;
      reg_req = '0;
      n_mismatch = 0;
      tests_run = 0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
      $display("reset values done");
      k = rnd[7:0];
      run('{{8'h0e, k}, {8'h09, 8'h35}}, 8'h00);
      rd(3'h0, k | 8'h35);
      rd(3'h2, {6'h00, k[7], 1'b0});
      run('{{8'h0e, 8'h00}}, 8'h00);
      rd(3'h2, {6'h00, k[7], 1'b0});
      run('{{8'h09, 8'h00}}, 8'h00);
      rd(3'h2, 8'h01);
      $display("immediate ops done");
      run('{{8'h01, 8'ha5}, {8'h0e, 8'h3c}, {`BOD_OP_STACC, 9'h1ff}, {8'h0e, 8'h00}, {`BOD_OP_MOVLOC, 10'h1ff}},
         8'h00);
      rd(3'h1, 8'h05);
      rd(3'h0, 8'h3c);
      rd(3'h2, 8'h00);
      run('{{8'h0e, 8'h81}, {`BOD_OP_STACC, 9'h010}, {8'h01, 8'h00}, {8'h0e, 8'h00}, {`BOD_OP_MOVLOC, 10'h110}},
         8'h00);
      rd(3'h0, 8'h81);
      $display("bank access done");
      run('{{8'h0e, 8'hff}, {`BOD_OP_STACC, 9'h020}, {`BOD_OP_INCSZ, 10'h220}, {8'h0e, 8'h11},
         {`BOD_OP_INCSNZ, 10'h020}, {8'h0e, 8'h22}}, 8'h02);
      rd(3'h0, 8'h01);
      rd(3'h2, 8'h02);
      run('{{`BOD_OP_INCSNZ, 10'h020}, {8'hee, 8'h2f}, {8'hf0, 8'hff}, {8'h0e, 8'h44}}, 8'h01);
      rd(3'h0, 8'h44);
      $display("skips done");
      run('{{8'hee, 8'h21}, {8'hf0, 8'h23}, {8'h0e, 8'h77}}, 8'h00);
      wr_rd(3'h3, 8'h01, 8'h01);
      run('{{`BOD_OP_STACC, 9'h005}}, 8'h00);
      wr(3'h3, 8'h00);
      run('{{8'h01, 8'h01}, {8'h0e, 8'h00}, {`BOD_OP_MOVLOC, 10'h128}}, 8'h00);
      rd(3'h0, 8'h77);
      $display("pointer indexing done");
      run('{{8'hc1, 8'h28}, {8'hf3, 8'h45}, {8'h01, 8'h03}, {8'h0e, 8'h00}, {`BOD_OP_MOVLOC, 10'h145}}, 8'h00);
      rd(3'h0, 8'h77);
      run('{{8'h0e, 8'h80}, {`BOD_OP_ORLOC, 10'h145}}, 8'h00);
      rd(3'h0, 8'hf7);
      rd(3'h2, 8'h02);
      $display("memory move done");
      wr_rd(3'h0, 8'h5a, 8'h5a);
      wr(3'h1, 8'hff);
      rd(3'h1, 8'h03);
      $display("register port done");
      repeat (3) @(posedge clk);
      tally_and_finish;
   end
endmodule // bod_core_tb_top
